// File: core/timer8_pkg.sv
// Purpose: constants shared by the 8-bit wave timer and its prescaler
// Assumes: registers reached over a plain strobe port, byte address = 4 * index
// Notes:   bit layouts of the control registers are fixed here
//
// What this block does
// R01: only wave mode selects the counting sequence
// R02: normal mode counts up, wraps 0xFF to 0x00
// R03: normal mode sets wrap flag as count hits zero
// R04: counting only sets wrap flag; interrupt ack clears
// R05: normal mode accepts count writes at any time
// R06: clear-on-match mode clears count on compare match
// R07: clear-on-match compare unbuffered; missed match wraps first
// R08: clear-on-match sets match flag at every match
// R09: clear-on-match action 1 toggles output per match
// R10: pin driven only while direction is output
// R11: toggle frequency is clock over 2*N*(1+compare)
// R12: prescale factors 1, 8, 64, 256, 1024
// R13: clear-on-match sets wrap flag passing max to zero
// R14: fast PWM counts up to max, then bottom
// R15: fast PWM action 2 clear-on-match, action 3 inverted
// R16: fast PWM sets wrap flag at every max
// R17: fast PWM period is 256 timer cycles
// R18: fast PWM compare 0 spikes; compare max constant
// R19: software avoids waveforms in normal mode
// R20: compare double-buffered in PWM, loaded at bottom
// R21: count write blocks match in next timer cycle
// R22: counter moves only on prescaler timer-clock enable

package timer8_pkg;

  ////////////////////////////////////////////////////////////////
  // register bus
  localparam int         ADDR_W      = 8;              // byte address width
  localparam int         DATA_W      = 8;              // register width
  localparam logic [7:0] IDX_CTRL    = 8'h00;          // mode, action, clock select
  localparam logic [7:0] IDX_COUNT   = 8'h01;          // count_value
  localparam logic [7:0] IDX_COMPARE = 8'h02;          // compare_value
  localparam logic [7:0] IDX_FLAGS   = 8'h03;          // wrap and match flags
  localparam logic [7:0] IDX_PIN     = 8'h04;          // pin direction and port level
  localparam logic [7:0] ADDR_CTRL    = 8'(IDX_CTRL * 4);
  localparam logic [7:0] ADDR_COUNT   = 8'(IDX_COUNT * 4);
  localparam logic [7:0] ADDR_COMPARE = 8'(IDX_COMPARE * 4);
  localparam logic [7:0] ADDR_FLAGS   = 8'(IDX_FLAGS * 4);
  localparam logic [7:0] ADDR_PIN     = 8'(IDX_PIN * 4);

  ////////////////////////////////////////////////////////////////
  // control field positions
  localparam int CTRL_MODE_LSB  = 0;                   // wave_mode_sel [1:0]
  localparam int CTRL_ACT_LSB   = 2;                   // out_action_sel [3:2]
  localparam int CTRL_CLK_LSB   = 4;                   // clock select [6:4]
  localparam int CTRL_FORCE_BIT = 7;                   // force_match_strobe, reads 0
  localparam int FLAG_WRAP_BIT  = 0;                   // wrap_flag, write 1 clears
  localparam int FLAG_MATCH_BIT = 1;                   // match_flag, write 1 clears
  localparam int PIN_DIR_BIT    = 0;                   // 1 = pin is an output
  localparam int PIN_PORT_BIT   = 1;                   // plain port level
  localparam int PIN_WAVE_BIT   = 2;                   // wave state, read only

  ////////////////////////////////////////////////////////////////
  // modes, actions and counts
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;           // treated as buffered up-count
  localparam logic [1:0] MODE_CTC    = 2'h2;           // clear_on_match_mode
  localparam logic [1:0] MODE_FAST   = 2'h3;
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] ACT_CLEAR   = 2'h2;
  localparam logic [1:0] ACT_SET     = 2'h3;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // clock select codes, 0 stops the timer
  localparam logic [2:0] CLK_STOP = 3'h0;
  localparam logic [2:0] CLK_1    = 3'h1;
  localparam logic [2:0] CLK_8    = 3'h2;
  localparam logic [2:0] CLK_64   = 3'h3;
  localparam logic [2:0] CLK_256  = 3'h4;
  localparam logic [2:0] CLK_1024 = 3'h5;
  localparam int         PRE_W    = 10;                // prescaler counter width
  localparam logic [9:0] DIV_8    = 10'h007;           // terminal counts, factor - 1
  localparam logic [9:0] DIV_64   = 10'h03F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;

endpackage : timer8_pkg

// File: core/timer8_prescale.sv
// Purpose: timer clock enable from the system clock
// Assumes: one free-running divider shared by all factors
// Notes:   tick is a one-cycle enable, never a derived clock
`timescale 1ns/10ps
`default_nettype none

module timer8_prescale (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  // selection and enable
  input  wire logic [2:0]                    clk_sel,
  output logic                               tick
);
  import timer8_pkg::*;

  // all state of the divider
  typedef struct packed {
    logic [PRE_W-1:0] div;                             // free-running divider
  } pre_state_t;

  pre_state_t state_reg;                               // registered state
  pre_state_t state_next;                              // next state

  // terminal count hit for a given factor
  function automatic logic div_hit(input logic [PRE_W-1:0] cnt, input logic [PRE_W-1:0] term);
    div_hit = ((cnt & term) == term);
  endfunction : div_hit

  // divider runs freely; a factor change may give one short first period
  always_comb begin
    state_next     = state_reg;
    state_next.div = state_reg.div + 10'h001;
  end

  // select the enable for the chosen factor
  always_comb begin
    unique case (clk_sel)
      CLK_1:    tick = 1'b1;                           // R12
      CLK_8:    tick = div_hit(state_reg.div, DIV_8);    // R12
      CLK_64:   tick = div_hit(state_reg.div, DIV_64);   // R12
      CLK_256:  tick = div_hit(state_reg.div, DIV_256);  // R12
      CLK_1024: tick = div_hit(state_reg.div, DIV_1024); // R12
      default:  tick = 1'b0;                           // stopped or unused code
    endcase
  end

  // register the divider
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : timer8_prescale

`default_nettype wire

// File: core/timer8_wave_modes.sv
// Purpose: 8-bit timer with normal, clear-on-match and fast PWM modes
// Assumes: software port strobes are synchronous and one cycle long
// Notes:   pin outputs lag the internal wave state by one cycle
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module timer8_wave_modes (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  // register port
  input  wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [timer8_pkg::DATA_W-1:0] reg_rdata,
  // interrupt acknowledges from the core
  input  wire logic                          wrap_int_ack,
  input  wire logic                          match_int_ack,
  // event flags
  output logic                               wrap_flag,
  output logic                               match_flag,
  // waveform pin
  output logic                               wave_pin_o,
  output logic                               wave_pin_oe
);
  import timer8_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state

  // every flop of the block
  typedef struct packed {
    logic [1:0] wave_mode_sel;                         // counting sequence
    logic [1:0] out_action_sel;                        // output behaviour
    logic [2:0] clk_sel;                               // prescaler choice
    logic [7:0] count_value;                           // the counter
    logic [7:0] compare_value;                         // value in use
    logic [7:0] compare_buf;                           // software copy
    logic       wrap_flag;                             // sticky wrap event
    logic       match_flag;                            // sticky match event
    logic       block;                                 // match blocked after count write
    logic       wave;                                  // internal wave state
    logic       dir;                                   // pin is output
    logic       port;                                  // port level when not overridden
    logic       pin_o;                                 // pin level
    logic       pin_oe;                                // pin enable
    logic [7:0] rdata;                                 // read answer
  } tmr_state_t;

  tmr_state_t state_reg;                               // registered state
  tmr_state_t state_next;                              // next state

  logic tick;                                          // timer clock enable
  logic wr_ctrl;                                       // write decodes
  logic wr_count;
  logic wr_cmp;
  logic wr_flags;
  logic wr_pin;
  logic at_max;                                        // counter at max
  logic hit;                                           // live compare match
  logic wrap_set;                                      // wrap event this cycle
  logic match_set;                                     // match event this cycle
  logic force_hit;                                     // forced match
  logic pwm_mode;                                      // buffered compare modes
  logic wave_calc;                                     // next wave state

  ////////////////////////////////////////////////////////////////
  // prescaler

  // one enable per timer clock cycle
  timer8_prescale u_prescale (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_sel  (state_reg.clk_sel),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////
  // helpers

  // output action on a compare match in the non-PWM modes
  function automatic logic act_level(input logic [1:0] act, input logic cur);
    unique case (act)
      ACT_TOGGLE: act_level = ~cur;
      ACT_CLEAR:  act_level = 1'b0;
      ACT_SET:    act_level = 1'b1;
      default:    act_level = cur;
    endcase
  endfunction : act_level

  ////////////////////////////////////////////////////////////////
  // decode and events

  // address decode; unmapped addresses are ignored
  always_comb begin
    wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
    wr_count = reg_wr && (reg_addr == ADDR_COUNT);
    wr_cmp   = reg_wr && (reg_addr == ADDR_COMPARE);
    wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);
    wr_pin   = reg_wr && (reg_addr == ADDR_PIN);
  end

  // events only on the timer clock enable, except the forced match on a control write
  always_comb begin
    pwm_mode  = state_reg.wave_mode_sel[0];
    at_max    = (state_reg.count_value == COUNT_MAX);
    hit       = tick && !state_reg.block &&
                (state_reg.count_value == state_reg.compare_value); // R21 R22
    wrap_set  = tick && at_max;                        // R03 R13 R16
    match_set = hit;                                   // R08
    force_hit = wr_ctrl && reg_wdata[CTRL_FORCE_BIT] && !reg_wdata[CTRL_MODE_LSB];
  end

  // next wave state; mode bits alone decide PWM behaviour
  always_comb begin
    wave_calc = state_reg.wave;
    if (state_reg.wave_mode_sel == MODE_FAST) begin
      // bottom set wins over match so compare at max gives a constant level
      if (wrap_set && state_reg.out_action_sel[1]) begin
        wave_calc = ~state_reg.out_action_sel[0];      // R15 R18
      end else if (hit && state_reg.out_action_sel[1]) begin
        wave_calc = state_reg.out_action_sel[0];       // R15 R18
      end
    end else if (!pwm_mode && (hit || force_hit)) begin
      // force uses the action bits as they stand before this write
      wave_calc = act_level(state_reg.out_action_sel, state_reg.wave); // R09 R11
    end
  end

  ////////////////////////////////////////////////////////////////
  // next state

  // counter, flags, registers and read path
  always_comb begin
    state_next = state_reg;

    // counting sequence from the mode bits only
    if (tick) begin
      state_next.block = 1'b0;                         // R21
      unique case (state_reg.wave_mode_sel)
        MODE_CTC: begin
          // match clears; a missed match runs on through max
          if (hit) begin
            state_next.count_value = COUNT_BOTTOM;     // R06
          end else begin
            state_next.count_value = state_reg.count_value + 8'h01; // R07 R13
          end
        end
        default: begin
          // plain up-count wrapping max to bottom
          state_next.count_value = state_reg.count_value + 8'h01; // R01 R02 R14 R17
        end
      endcase
      // buffered compare loads as the count returns to bottom
      if (pwm_mode && at_max) begin
        state_next.compare_value = state_reg.compare_buf; // R20
      end
    end

    // flags: set wins over any clear
    if (wrap_set) begin
      state_next.wrap_flag = 1'b1;                     // R03 R04
    end else if (wrap_int_ack || (wr_flags && reg_wdata[FLAG_WRAP_BIT])) begin
      state_next.wrap_flag = 1'b0;                     // R04
    end
    if (match_set) begin
      state_next.match_flag = 1'b1;                    // R08
    end else if (match_int_ack || (wr_flags && reg_wdata[FLAG_MATCH_BIT])) begin
      state_next.match_flag = 1'b0;
    end

    state_next.wave = wave_calc;

    // software writes
    if (wr_ctrl) begin
      state_next.wave_mode_sel  = reg_wdata[CTRL_MODE_LSB +: 2];
      state_next.out_action_sel = reg_wdata[CTRL_ACT_LSB +: 2];
      state_next.clk_sel        = reg_wdata[CTRL_CLK_LSB +: 3];
    end
    if (wr_count) begin
      // write wins over the count and blocks the next match
      state_next.count_value = reg_wdata;              // R05
      state_next.block       = 1'b1;                   // R21
    end
    if (wr_cmp) begin
      state_next.compare_buf = reg_wdata;
      if (!pwm_mode) begin
        state_next.compare_value = reg_wdata;          // R07 R20
      end
    end
    if (wr_pin) begin
      state_next.dir  = reg_wdata[PIN_DIR_BIT];
      state_next.port = reg_wdata[PIN_PORT_BIT];
    end

    // pin: wave overrides the port level when any action bit is set
    state_next.pin_oe = state_reg.dir;                 // R10
    state_next.pin_o  = state_reg.dir &&
                        ((state_reg.out_action_sel != ACT_NONE) ? state_reg.wave : state_reg.port); // R10

    // read answer the cycle after the strobe, zero otherwise
    state_next.rdata = RESET_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:    state_next.rdata = {1'b0, state_reg.clk_sel, state_reg.out_action_sel,
                                          state_reg.wave_mode_sel};
        ADDR_COUNT:   state_next.rdata = state_reg.count_value;
        ADDR_COMPARE: state_next.rdata = state_reg.compare_buf;
        ADDR_FLAGS:   state_next.rdata = {6'h00, state_reg.match_flag, state_reg.wrap_flag};
        ADDR_PIN:     state_next.rdata = {5'h00, state_reg.wave, state_reg.port, state_reg.dir};
        default:      state_next.rdata = RESET_BYTE;   // unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers

  // single state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata   = state_reg.rdata;
  assign wrap_flag   = state_reg.wrap_flag;
  assign match_flag  = state_reg.match_flag;
  assign wave_pin_o  = state_reg.pin_o;
  assign wave_pin_oe = state_reg.pin_oe;

  ////////////////////////////////////////////////////////////////
  // checks

  // normal mode wraps to bottom and raises the wrap flag
  a_normal_wrap_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // R02
    (tick && at_max && state_reg.wave_mode_sel == MODE_NORMAL && !wr_count && !wr_ctrl)
    |=> (state_reg.count_value == 8'h00) && state_reg.wrap_flag)
    else $error("normal mode wrap missed");

  // normal mode steps by one per tick
  a_normal_step: assert property (@(posedge core_clk) disable iff (!reset_n) // R01
    (tick && state_reg.wave_mode_sel == MODE_NORMAL && !wr_count)
    |=> state_reg.count_value == 8'($past(state_reg.count_value) + 8'h01))
    else $error("normal count did not step");

  // counter holds without a tick
  a_count_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // R22
    (!tick && !wr_count) |=> $stable(state_reg.count_value))
    else $error("count moved without tick");

  // clear-on-match resets the count and flags the match
  a_ctc_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // R06
    (hit && state_reg.wave_mode_sel == MODE_CTC && !wr_count)
    |=> (state_reg.count_value == 8'h00) && state_reg.match_flag)
    else $error("clear on match failed");

  // wrap flag stays until acknowledged
  a_wrap_sticky: assert property (@(posedge core_clk) disable iff (!reset_n) // R04
    (state_reg.wrap_flag && !wrap_int_ack && !wr_flags) |=> state_reg.wrap_flag)
    else $error("wrap flag dropped");

  // acknowledge clears unless a new wrap lands
  a_wrap_ack: assert property (@(posedge core_clk) disable iff (!reset_n) // R04
    (wrap_int_ack && !wrap_set) |=> !state_reg.wrap_flag)
    else $error("wrap ack ignored");

  // toggle action flips the wave on every match in clear-on-match mode
  a_ctc_toggle: assert property (@(posedge core_clk) disable iff (!reset_n) // R09
    (hit && state_reg.wave_mode_sel == MODE_CTC && state_reg.out_action_sel == ACT_TOGGLE)
    |=> state_reg.wave != $past(state_reg.wave))
    else $error("toggle missed");

  // pin undriven while direction is input
  a_pin_gate: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    !state_reg.dir |=> (!wave_pin_oe && !wave_pin_o))
    else $error("pin driven as input");

  // fast PWM non-inverting sets at bottom
  a_fast_bottom: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
    (wrap_set && state_reg.wave_mode_sel == MODE_FAST && state_reg.out_action_sel == ACT_CLEAR
     && !wr_count && !wr_ctrl)
    |=> state_reg.wave && (state_reg.count_value == 8'h00) && state_reg.wrap_flag)
    else $error("fast pwm bottom wrong");

  // buffered compare unchanged until bottom
  a_fast_buffer: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
    (wr_cmp && pwm_mode && !(tick && at_max)) |=> $stable(state_reg.compare_value))
    else $error("pwm compare not buffered");

  // count write blocks the match of the next tick
  a_write_block: assert property (@(posedge core_clk) disable iff (!reset_n) // R21
    (wr_count && !hit && !state_reg.match_flag) ##1 (tick && !match_int_ack && !wr_flags)
    |=> !state_reg.match_flag)
    else $error("match not blocked");

  // forced match never sets the match flag
  a_force_noflag: assert property (@(posedge core_clk) disable iff (!reset_n) // R08
    (force_hit && !hit && !state_reg.match_flag) |=> !state_reg.match_flag)
    else $error("force set match flag");

  // a missed top runs on through max and wraps
  // before the next match can clear the count
  a_ctc_run_on: assert property (@(posedge core_clk) disable iff (!reset_n) // R07
    (tick && !hit && state_reg.wave_mode_sel == MODE_CTC && !wr_count)
    |=> state_reg.count_value == 8'($past(state_reg.count_value) + 8'h01))
    else $error("count did not run on");

  // clear-on-match passing max raises the wrap flag
  // whatever the compare value holds
  a_ctc_wrap: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
    (tick && at_max && state_reg.wave_mode_sel == MODE_CTC) |=> state_reg.wrap_flag)
    else $error("ctc wrap missed");

  // fast PWM non-inverting clears on a match below max
  // the wrap tick is left out, bottom set wins there
  a_fast_match: assert property (@(posedge core_clk) disable iff (!reset_n) // R15
    (hit && !wrap_set && state_reg.wave_mode_sel == MODE_FAST && state_reg.out_action_sel == ACT_CLEAR)
    |=> !state_reg.wave)
    else $error("fast pwm match did not clear");

  // buffered compare takes the software copy at the wrap tick
  // so a period never sees two compare values
  a_pwm_load: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
    (tick && at_max && pwm_mode) |=> state_reg.compare_value == $past(state_reg.compare_buf))
    else $error("pwm compare not loaded at bottom");

  // pin follows the wave state once action bits override
  // the port level, one cycle behind
  a_pin_wave: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
    (state_reg.dir && state_reg.out_action_sel != ACT_NONE)
    |=> wave_pin_oe && (wave_pin_o == $past(state_reg.wave)))
    else $error("pin does not follow wave");

endmodule : timer8_wave_modes

`default_nettype wire

// File: sim/wave_load.sv
// Purpose: load on the waveform pin, resolves the wire level
// Assumes: a weak pull-down on the board side
// Notes:   the wire sinks low whenever the timer lets go of it
`timescale 1ns/10ps
`default_nettype none

module wave_load (
  // pin from the timer
  input  wire logic wave_pin_o,
  input  wire logic wave_pin_oe,
  // level seen by the load
  output logic      pin_level
);
  // pull-down wins while the driver is off, never a stale level
  assign pin_level = wave_pin_oe ? wave_pin_o : 1'b0;
endmodule : wave_load
`default_nettype wire

// File: sim/timer8_wave_modes_test.sv
// Purpose: self-checking bench for the 8-bit wave timer
// Assumes: register port with one-cycle strobes, data one cycle later
// Notes:   pwm figures are taken over two whole periods, so phase drops out
`timescale 1ns/10ps
`default_nettype none

module timer8_wave_modes_test;
  import timer8_pkg::*;
  logic       core_clk = 1'b0;      // 40 MHz
  logic       reset_n  = 1'b0;      // active low
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, wrap_int_ack = 1'b0, match_int_ack = 1'b0;
  logic       wrap_flag, match_flag, wave_pin_o, wave_pin_oe, pin_level;
  int         failures = 0, cmp_count = 0, cycles = 0, hi, tg;
  // fast pwm cases: compare, action, high cycles and edges per 512
  logic [7:0] pwm_cmp [5] = '{8'h80, 8'h80, 8'hFF, 8'h00, 8'hFF};
  logic [1:0] pwm_act [5] = '{ACT_CLEAR, ACT_SET, ACT_CLEAR, ACT_CLEAR, ACT_SET};
  int         pwm_hi  [5] = '{258, 254, 512, 2, 0};
  int         pwm_tg  [5] = '{4, 4, 0, 4, 0};
  int         pre_n   [4] = '{8, 64, 256, 1024};

  ////////////////////////////////////////////////////////////////
  timer8_wave_modes dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wrap_int_ack(wrap_int_ack), .match_int_ack(match_int_ack), .wrap_flag(wrap_flag),
    .match_flag(match_flag), .wave_pin_o(wave_pin_o), .wave_pin_oe(wave_pin_oe));
  wave_load load (.wave_pin_o(wave_pin_o), .wave_pin_oe(wave_pin_oe), .pin_level(pin_level));

  // clock and hang guard
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // write, one idle cycle after so strobes never double-assign
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // read, data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  // interrupt taken pulse, wrap or match
  task automatic ack(input logic w);
    wrap_int_ack  <= w;
    match_int_ack <= !w;
    @(posedge core_clk);
    wrap_int_ack  <= 1'b0;
    match_int_ack <= 1'b0;
    @(posedge core_clk);
  endtask : ack
  // high cycles and level changes of the wire over n cycles
  task automatic meas(input int n);
    logic p;
    hi = 0;
    tg = 0;
    #1 p = pin_level;
    repeat (n) begin
      @(posedge core_clk);
      #1 hi += int'(pin_level);
      tg += int'(pin_level != p);
      p = pin_level;
    end
  endtask : meas
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // reset values, force bit reads 0, unmapped place stays 0
    wr(8'h14, 8'hFF);
    wr(ADDR_CTRL, 8'h80);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("register", 16'h0000, {8'h00, rd_val});
    end
    // force in normal mode applies the action bits already held
    wr(ADDR_CTRL, {1'b0, CLK_STOP, ACT_SET, MODE_NORMAL});
    wr(ADDR_CTRL, {1'b1, CLK_STOP, ACT_SET, MODE_NORMAL});
    rd(ADDR_PIN);
    chk("forced wave", 16'h0004, {8'h00, rd_val});
    chk("force no flag", 16'h0000, {15'h0, match_flag});
    // normal mode, count written while running
    wr(ADDR_CTRL, {1'b0, CLK_1, ACT_NONE, MODE_NORMAL});
    wr(ADDR_COUNT, 8'hFE);
    repeat (4) @(posedge core_clk);
    chk("wrap set", 16'h0001, {15'h0, wrap_flag});
    repeat (20) @(posedge core_clk);
    chk("wrap held", 16'h0001, {15'h0, wrap_flag});
    wr(ADDR_CTRL, 8'h00);
    ack(1'b1);
    chk("wrap acked", 16'h0000, {15'h0, wrap_flag});
    // clear-on-match toggle, top 3 gives an 8 cycle period
    wr(ADDR_COMPARE, 8'h03);
    wr(ADDR_PIN, 8'h01);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_CTRL, {1'b0, CLK_1, ACT_TOGGLE, MODE_CTC});
    repeat (8) @(posedge core_clk);
    meas(64);
    chk("toggle high", 16'd32, 16'(hi));
    chk("toggle edges", 16'd16, 16'(tg));
    chk("match set", 16'h0001, {15'h0, match_flag});
    rd(ADDR_COUNT);
    chk("count top", 16'h0000, {10'h0, rd_val[7:2]});
    wr(ADDR_PIN, 8'h00);
    meas(16);
    chk("pin released", 16'h0000, {wave_pin_oe, wave_pin_o, 14'(hi)});
    wr(ADDR_CTRL, {1'b0, CLK_STOP, ACT_NONE, MODE_CTC});
    ack(1'b0);
    chk("match acked", 16'h0000, {15'h0, match_flag});
    // count written equal to compare: match blocked, so it wraps first
    wr(ADDR_COMPARE, 8'h05);
    wr(ADDR_COUNT, 8'h05);
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_CTRL, {1'b0, CLK_1, ACT_NONE, MODE_CTC});
    for (int i = 0; i < 300 && match_flag !== 1'b1; i++) @(posedge core_clk);
    chk("late match", 16'h0001, {15'h0, match_flag});
    chk("wrap before match", 16'h0001, {15'h0, wrap_flag});
    // fast pwm polarity and compare edge cases
    wr(ADDR_PIN, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_COMPARE, pwm_cmp[i]);
      wr(ADDR_CTRL, {1'b0, CLK_1, pwm_act[i], MODE_FAST});
      repeat (300) @(posedge core_clk);
      meas(512);
      chk("pwm high", 16'(pwm_hi[i]), 16'(hi));
      chk("pwm edges", 16'(pwm_tg[i]), 16'(tg));
    end
    wr(ADDR_FLAGS, 8'h01);
    repeat (260) @(posedge core_clk);
    chk("pwm wrap", 16'h0001, {15'h0, wrap_flag});
    // prescaled counting: 4 or 5 ticks in 4N+1 edges
    for (int c = 2; c < 6; c++) begin
      wr(ADDR_CTRL, {1'b0, 3'(c), ACT_NONE, MODE_NORMAL});
      wr(ADDR_COUNT, 8'h00);
      repeat (4 * pre_n[c - 2]) @(posedge core_clk);
      rd(ADDR_COUNT);
      chk("prescale ticks", 16'h0002, {9'h0, rd_val[7:1]});
    end
    end_of_test();
  end
endmodule : timer8_wave_modes_test
`default_nettype wire
